// ===== logic/blf_supervisor.sv
// Top: fault supervisor state machine, gate control and AXI4-Lite registers
`timescale 1ns/1ps
module blf_supervisor #(
	parameter int unsigned OPEN_CYC = blf_pkg::OPEN_CHK_CYC,
	parameter int unsigned OVP_CYC = blf_pkg::OVP_HOLD_CYC,
	parameter int unsigned LED_CYC = blf_pkg::LED_LOW_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input blf_pkg::blf_cmp_t cmp_in,
	output logic gate_drive_out,
	output logic raise_out,
	output logic clamp_rise,
	output logic ss_discharge,
	output logic fault_o,
	output logic fault_oe,
	output logic irq,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import blf_pkg::*;

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	blf_cmp_t cmp;
	logic cyc_d_q;
	logic cyc_tick;

	blf_sync #(
		.W($bits(blf_cmp_t))
	) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.d(cmp_in),
		.q(cmp)
	);

	// Switching cycle start from the synchronised oscillator edge
	always_ff @(posedge sys_clk) begin
		if (rst)
			cyc_d_q <= 1'b0;
		else
			cyc_d_q <= cmp.cycle_clk;
	end
	assign cyc_tick = cmp.cycle_clk & ~cyc_d_q;

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	logic [0:0] ctrl_q;
	logic [N_EV-1:0] irq_stat_q;
	logic [N_EV-1:0] irq_en_q;
	blf_cause_t cause_q;
	logic sw_en;
	logic run_en;

	assign sw_en = ctrl_q[0];
	// Software enable is ANDed with the pin so either can hold it off
	assign run_en = cmp.enable & sw_en;

	// ----------------------------------------
	// Persistence timers
	// ----------------------------------------
	blf_state_t state_q;
	logic [N_TMR-1:0] tmr_cond;
	logic [N_TMR-1:0] tmr_exp;
	localparam int unsigned LIMITS [N_TMR] = '{OPEN_CYC, OVP_CYC,
		LED_CYC, LED_CYC};

	// Conditions only while the stage they guard is active
	assign tmr_cond[0] = (state_q == ST_CHECK) & cmp.fb_low;
	assign tmr_cond[1] = (state_q == ST_RUN) & cmp.fb_over;
	// Open string shows as LED low at the clamp in dimming-on time
	assign tmr_cond[2] = (state_q == ST_RUN) & cmp.led_low
		& cmp.fb_over & cmp.dim_on;
	assign tmr_cond[3] = (state_q == ST_RUN) & cmp.led_low
		& cmp.cs_ocp;

	genvar gi;
	generate
		for (gi = 0; gi < N_TMR; gi++) begin : g_tmr
			blf_persist #(
				.W(TMR_W),
				.LIMIT(LIMITS[gi])
			) u_tmr (
				.sys_clk(sys_clk),
				.rst(rst),
				.cond(tmr_cond[gi]),
				.expired(tmr_exp[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Diode short cycle counter
	// ----------------------------------------
	logic [1:0] short_cnt_q;
	logic short_seen_q;
	logic short_hit;

	// Counts consecutive switching cycles in which the 800 mV limit was touched
	always_ff @(posedge sys_clk) begin
		if (rst || state_q != ST_RUN) begin
			short_cnt_q <= 2'h0;
			short_seen_q <= 1'b0;
		end else if (cyc_tick) begin
			short_seen_q <= cmp.cs_short;
			if (short_seen_q || cmp.cs_short)
				short_cnt_q <= short_cnt_q + 2'h1;
			else
				short_cnt_q <= 2'h0;
		end else if (cmp.cs_short) begin
			short_seen_q <= 1'b1;
		end
	end
	assign short_hit = (short_cnt_q == SHORT_CYCLES);

	// ----------------------------------------
	// Supervisor state machine
	// ----------------------------------------
	logic latch_now;
	blf_cause_t cause_d;

	always_comb begin
		latch_now = 1'b1;
		cause_d = CAUSE_NONE;
		if (cmp.led_over)
			cause_d = CAUSE_LED_OVER;
		else if (tmr_exp[0])
			cause_d = CAUSE_OPEN;
		else if (short_hit)
			cause_d = CAUSE_SHORT;
		else if (tmr_exp[1])
			cause_d = CAUSE_OVP;
		else if (tmr_exp[2] || tmr_exp[3])
			cause_d = CAUSE_LED_LOW;
		else
			latch_now = 1'b0;
	end

	// Lockout and thermal retry; only enable low or reset leave latch
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= ST_OFF;
		end else begin
			unique case (state_q)
				ST_OFF: begin
					if (run_en && !cmp.lockout)
						state_q <= ST_CHECK;
				end
				ST_CHECK, ST_RUN: begin
					if (!run_en || cmp.lockout)
						state_q <= ST_OFF;
					else if (latch_now)
						state_q <= ST_LATCH;
					else if (cmp.hot)
						state_q <= ST_HOLD;
					else if (state_q == ST_CHECK && !cmp.fb_low)
						state_q <= ST_RUN;
				end
				ST_HOLD: begin
					if (!run_en || cmp.lockout)
						state_q <= ST_OFF;
					else if (!cmp.hot)
						state_q <= ST_RUN;
				end
				ST_LATCH: begin
					if (!run_en)
						state_q <= ST_OFF;
				end
				default: state_q <= ST_OFF;
			endcase
		end
	end

	// Cause of the last latch, kept until the next one
	always_ff @(posedge sys_clk) begin
		if (rst)
			cause_q <= CAUSE_NONE;
		else if ((state_q == ST_CHECK || state_q == ST_RUN) && run_en
			&& !cmp.lockout && latch_now)
			cause_q <= cause_d;
	end

	// ----------------------------------------
	// Gate drive and analog steering outputs
	// ----------------------------------------
	logic ocp_cut_q;
	logic running;
	logic fault_now;

	assign running = (state_q == ST_RUN) && run_en && !cmp.lockout
		&& !cmp.hot && !latch_now;

	// Cut holds to the next cycle; a new trip in the tick cycle wins
	always_ff @(posedge sys_clk) begin
		if (rst)
			ocp_cut_q <= 1'b0;
		else if (cmp.cs_ocp)
			ocp_cut_q <= 1'b1;
		else if (cyc_tick)
			ocp_cut_q <= 1'b0;
	end

	assign fault_now = (state_q == ST_LATCH) || (state_q == ST_HOLD)
		|| cmp.lockout || cmp.hot;

	// Gate is dropped at the clock edge after a hard fault is seen
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gate_drive_out <= 1'b0;
			raise_out <= 1'b0;
			clamp_rise <= 1'b0;
			ss_discharge <= 1'b0;
		end else begin
			gate_drive_out <= running && cmp.pwm_on && !cmp.cs_ocp
				&& !ocp_cut_q && !cmp.fb_over;
			raise_out <= running && cmp.led_low && !cmp.fb_over
				&& !ocp_cut_q;
			clamp_rise <= running && cmp.fb_over;
			ss_discharge <= (state_q == ST_LATCH);
		end
	end

	// Open drain: driving low while normal, released on any fault
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fault_o <= 1'b0;
			fault_oe <= 1'b1;
		end else begin
			fault_o <= 1'b0;
			fault_oe <= !fault_now;
		end
	end

	// ----------------------------------------
	// Interrupt events
	// ----------------------------------------
	logic [N_EV-1:0] ev;
	logic clamp_d_q;
	logic [N_EV-1:0] irq_clr;

	always_ff @(posedge sys_clk) begin
		if (rst)
			clamp_d_q <= 1'b0;
		else
			clamp_d_q <= clamp_rise;
	end

	// Latch event follows the same gate as the state move into LATCH
	always_comb begin
		ev = '0;
		ev[EV_LATCH] = latch_now && run_en && !cmp.lockout
			&& (state_q == ST_CHECK || state_q == ST_RUN);
		ev[EV_THERMAL] = cmp.hot && state_q == ST_RUN;
		ev[EV_LOCKOUT] = cmp.lockout && state_q != ST_OFF;
		ev[EV_OCP] = cmp.cs_ocp && !ocp_cut_q;
		ev[EV_CLAMP] = clamp_rise && !clamp_d_q;
	end

	// Sticky bits; an event in the clear cycle survives the clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_stat_q <= '0;
			irq <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | ev;
			irq <= |((irq_stat_q | ev) & irq_en_q);
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_go;
	logic [31:0] rd_val;
	logic rd_ok;

	assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
	assign irq_clr = (wr_go && waddr_q == ADDR_IRQ_CLR && wstrb_q[0])
		? wdata_q[N_EV-1:0] : '0;

	// Address and data are taken independently, one write at a time
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			waddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready
				&& s_axi_awvalid;
			s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				waddr_q <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (waddr_q == ADDR_CTRL
					|| waddr_q == ADDR_IRQ_CLR
					|| waddr_q == ADDR_IRQ_EN) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Writable registers; only byte lane 0 carries bits
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_q <= CTRL_RST;
			irq_en_q <= IRQ_EN_RST;
		end else if (wr_go && wstrb_q[0]) begin
			if (waddr_q == ADDR_CTRL)
				ctrl_q <= wdata_q[0:0];
			if (waddr_q == ADDR_IRQ_EN)
				irq_en_q <= wdata_q[N_EV-1:0];
		end
	end

	// Read decode; unmapped offsets return zero with SLVERR
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok = 1'b1;
		unique case (s_axi_araddr[7:0])
			ADDR_CTRL: rd_val[0] = ctrl_q[0];
			ADDR_STATUS: rd_val = {22'h000000, cmp.hot, cmp.lockout,
				fault_now, ocp_cut_q, clamp_rise, gate_drive_out,
				ss_discharge, state_q};
			ADDR_IRQ_STAT: rd_val[N_EV-1:0] = irq_stat_q;
			ADDR_IRQ_EN: rd_val[N_EV-1:0] = irq_en_q;
			ADDR_CAUSE: rd_val[2:0] = cause_q;
			ADDR_IRQ_CLR: rd_val = 32'h0000_0000;
			default: rd_ok = 1'b0;
		endcase
	end

	// Read answers one cycle after the address is taken
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid
				&& s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : blf_supervisor

// ===== common/blf_pkg.sv
// Package: constants, types and register map of the LED boost fault supervisor
package blf_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_KHZ = 40_000;
	localparam int unsigned OPEN_CHK_MS = 80;
	localparam int unsigned OVP_HOLD_MS = 640;
	localparam int unsigned LED_LOW_MS = 60;
	localparam int unsigned OPEN_CHK_CYC = OPEN_CHK_MS * CLK_KHZ;
	localparam int unsigned OVP_HOLD_CYC = OVP_HOLD_MS * CLK_KHZ;
	localparam int unsigned LED_LOW_CYC = LED_LOW_MS * CLK_KHZ;
	localparam logic [1:0] SHORT_CYCLES = 2'h3;
	localparam int unsigned TMR_W = 32;
	localparam int unsigned N_TMR = 4;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
	localparam logic [7:0] ADDR_CAUSE = 8'h14;
	localparam logic [0:0] CTRL_RST = 1'h1;
	localparam logic [4:0] IRQ_EN_RST = 5'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Interrupt event bit positions
	localparam int unsigned EV_LATCH = 0;
	localparam int unsigned EV_THERMAL = 1;
	localparam int unsigned EV_LOCKOUT = 2;
	localparam int unsigned EV_OCP = 3;
	localparam int unsigned EV_CLAMP = 4;
	localparam int unsigned N_EV = 5;

	// Latch cause codes
	typedef enum logic [2:0] {
		CAUSE_NONE = 3'h0,
		CAUSE_OPEN = 3'h1,
		CAUSE_SHORT = 3'h2,
		CAUSE_LED_OVER = 3'h3,
		CAUSE_OVP = 3'h4,
		CAUSE_LED_LOW = 3'h5
	} blf_cause_t;

	// Supervisor states, Gray along off-check-run-latch
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_CHECK = 3'h1,
		ST_RUN = 3'h3,
		ST_LATCH = 3'h2,
		ST_HOLD = 3'h7
	} blf_state_t;

	// Comparator and pin flags, all asynchronous to sys_clk
	typedef struct packed {
		logic fb_low;      // output_feedback_sense below 70 mV
		logic fb_over;     // output_feedback_sense above 3.04 V
		logic cs_ocp;      // switch_current_sense above 400 mV
		logic cs_short;    // switch_current_sense above 800 mV
		logic led_low;     // led_current_sense below 200 mV
		logic led_over;    // led_current_sense at 1.1 V
		logic hot;         // junction over temperature
		logic lockout;     // input_lockout_sense below 1.229 V
		logic enable;      // system enable pin
		logic cycle_clk;   // switching oscillator, rises per cycle
		logic dim_on;      // dimming PWM high
		logic pwm_on;      // PWM comparator asks for gate on
	} blf_cmp_t;

endpackage : blf_pkg

// ===== logic/blf_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module blf_sync #(
	parameter int unsigned W = 1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule : blf_sync

// ===== logic/blf_persist.sv
// Persistence timer: flags a condition that held for LIMIT cycles
`timescale 1ns/1ps
module blf_persist #(
	parameter int unsigned W = 32,
	parameter int unsigned LIMIT = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cond,
	output logic expired
);

	localparam logic [W-1:0] LAST = W'(LIMIT - 1);

	logic [W-1:0] cnt_q;

	// Count only while held; any drop restarts from zero
	always_ff @(posedge sys_clk) begin
		if (rst || !cond) begin
			cnt_q <= '0;
			expired <= 1'b0;
		end else begin
			if (cnt_q != LAST)
				cnt_q <= cnt_q + W'(1);
			expired <= (cnt_q == LAST);
		end
	end

endmodule : blf_persist

// ===== bench/blf_supervisor_props.sv
// Checker: timing relations at the fault supervisor pins
`timescale 1ns/1ps
module blf_supervisor_props (
	input wire logic sys_clk,
	input wire logic rst,
	input blf_pkg::blf_cmp_t cmp_in,
	input wire logic gate_drive_out,
	input wire logic raise_out,
	input wire logic clamp_rise,
	input wire logic ss_discharge,
	input wire logic fault_o,
	input wire logic fault_oe
);
	import blf_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Input patterns held long enough to cross the synchronisers
	sequence s_hot; cmp_in.hot [*4]; endsequence
	sequence s_lock; cmp_in.lockout [*4]; endsequence
	sequence s_trip; cmp_in.led_over [*3]; endsequence
	sequence s_calm; !cmp_in.fb_over [*4]; endsequence
	sequence s_kept; cmp_in.enable [*6] ##0 ss_discharge; endsequence
	// A latch must outlive everything except enable low and reset
	pin_low_a: assert property (fault_o == 1'b0)
		else $error("fault data bit not low");
	latch_gate_a: assert property (ss_discharge |-> !gate_drive_out)
		else $error("gate on while latched");
	latch_flag_a: assert property (ss_discharge |-> !fault_oe)
		else $error("fault pin held low while latched");
	latch_hold_a: assert property (s_kept |=> ss_discharge)
		else $error("latch left with enable high");
	hot_stop_a: assert property (s_hot |=> !gate_drive_out)
		else $error("gate on while hot");
	lock_stop_a: assert property (s_lock |=> !fault_oe && !gate_drive_out)
		else $error("lockout not reflected on pins");
	led_over_a: assert property (s_trip |=> !gate_drive_out)
		else $error("gate on after LED over voltage");
	clamp_gate_a: assert property (clamp_rise |-> !gate_drive_out)
		else $error("gate on while clamped");
	clamp_drop_a: assert property (s_calm |=> !clamp_rise)
		else $error("clamp without over voltage");
	raise_ok_a: assert property (raise_out |-> !clamp_rise && !ss_discharge)
		else $error("raise while clamped or latched");
endmodule : blf_supervisor_props
bind blf_supervisor blf_supervisor_props blf_supervisor_props_i (
	.sys_clk(sys_clk), .rst(rst), .cmp_in(cmp_in),
	.gate_drive_out(gate_drive_out), .raise_out(raise_out),
	.clamp_rise(clamp_rise), .ss_discharge(ss_discharge),
	.fault_o(fault_o), .fault_oe(fault_oe));

// ===== bench/blf_analog_model.sv
// Far-side model: oscillator, PWM comparator and switch current sense
`timescale 1ns/1ps
module blf_analog_model #(
	parameter int unsigned PER = 16,
	parameter int unsigned ON = 10
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic gate_drive_out,
	input wire logic ocp_req,
	input wire logic short_req,
	output logic cycle_clk,
	output logic pwm_on,
	output logic cs_ocp,
	output logic cs_short
);
	logic [7:0] phase_q;
	logic [7:0] on_q;
	// Free-running ramp, like the real oscillator
	always_ff @(posedge sys_clk) begin
		phase_q <= (rst || phase_q == 8'(PER - 1)) ? 8'h00 : phase_q + 8'h01;
	end
	// Inductor current builds only while the switch conducts
	always_ff @(posedge sys_clk) begin
		on_q <= (rst || !gate_drive_out) ? 8'h00 : on_q + 8'h01;
	end
	// Sense flags fall one clock after the gate opens, so a cut ends them
	assign cycle_clk = phase_q < 8'(PER / 2);
	assign pwm_on = phase_q < 8'(ON);
	assign cs_ocp = ocp_req && on_q > 8'h02;
	assign cs_short = short_req && on_q > 8'h00;
endmodule : blf_analog_model

// ===== bench/tb_top.sv
// Testbench: pin and register checks of the fault supervisor
`timescale 1ns/1ps
module tb_top;
	import blf_pkg::*;
	localparam int unsigned OPEN_N = 40;
	localparam int unsigned OVP_N = 200;
	localparam int unsigned LED_N = 30;
	localparam int unsigned PER = 16;
	localparam logic [31:0] ALL = 32'hffffffff;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] drv = 12'h000;
	logic [15:0] seed = 16'h0001;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rd;
	logic awr, wr, bv, arr, rv, osc, pwm, ocp, shrt;
	logic gate, raise, clamp, ssd, flt, flt_oe, irq;
	logic [1:0] br, rr;
	blf_cmp_t cmp;
	logic [1:0] bq[$];
	logic [65:0] rq[$];
	int err_count = 0;
	int checks = 0;
	// 40 MHz clock
	always #12.5 sys_clk = ~sys_clk;
	// Bench levels merged with the model's switching signals
	assign cmp = blf_cmp_t'({drv[11:10], ocp, shrt, drv[7:3], osc,
		drv[1], pwm});
	blf_analog_model #(.PER(PER), .ON(10)) blf_analog_model_i (
		.sys_clk(sys_clk), .rst(rst), .gate_drive_out(gate),
		.ocp_req(drv[9]), .short_req(drv[8]), .cycle_clk(osc),
		.pwm_on(pwm), .cs_ocp(ocp), .cs_short(shrt));
	blf_supervisor #(.OPEN_CYC(OPEN_N), .OVP_CYC(OVP_N), .LED_CYC(LED_N))
	blf_supervisor_i (
		.sys_clk(sys_clk), .rst(rst), .cmp_in(cmp), .gate_drive_out(gate),
		.raise_out(raise), .clamp_rise(clamp), .ss_discharge(ssd),
		.fault_o(flt), .fault_oe(flt_oe), .irq(irq),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rre));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic pin(input string name, input logic seen, input logic exp);
		check(name, {31'h0, seen}, {31'h0, exp});
	endtask : pin
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task automatic report_and_stop;
		$display("Checks %0d, errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic give_up;
		err_count++;
		$display("Error handshake expected answer seen none");
		report_and_stop();
	endtask : give_up
	// Write: both channels offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] resp);
		int n;
		n = 0;
		bq.push_back(resp);
		awa <= {24'h000000, a};
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			awv <= awv & ~awr;
			wv <= wv & ~wr;
		end while (((awv & ~awr) | (wv & ~wr)) && n < 40);
		bre <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!bv && n < 80);
		bre <= 1'b0;
		if (n >= 80) give_up();
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [1:0] resp);
		int n;
		n = 0;
		rq.push_back({m, resp, d});
		ara <= {24'h000000, a};
		arv <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!arr && n < 40);
		arv <= 1'b0;
		rre <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!rv && n < 80);
		rre <= 1'b0;
		if (n >= 80) give_up();
	endtask : axi_rd
	// Response watcher: oldest note against each completed transfer
	always @(posedge sys_clk) begin
		logic [65:0] e;
		if (bv && bre) check("bresp", {30'h0, br}, {30'h0, bq.pop_front()});
		if (rv && rre) begin
			e = rq.pop_front();
			check("rdata", rd & e[65:34], e[31:0]);
			check("rresp", {30'h0, rr}, {30'h0, e[33:32]});
		end
	end
	task automatic start;
		drv <= 12'h008;
		tick(12);
		axi_rd(ADDR_STATUS, 32'h3, 32'h7, RESP_OKAY);
		pin("fault_oe", flt_oe, 1'b1);
	endtask : start
	// Hold a fault pattern, probe before and after its limit, then clear
	task automatic latch_case(input logic [11:0] m, input int lim,
		input logic [2:0] cause, input bit by_rst);
		if (m[11]) tick(6);
		else start();
		drv <= 12'h008 | m;
		tick(lim - 10);
		pin("early", ssd, 1'b0);
		pin("clamp", clamp, m[10]);
		tick(50);
		pin("latched", ssd, 1'b1);
		pin("released", flt_oe, 1'b0);
		pin("irq_up", irq, 1'b1);
		axi_rd(ADDR_CAUSE, {29'h0, cause}, ALL, RESP_OKAY);
		drv <= 12'h008;
		axi_wr(ADDR_IRQ_CLR, 32'h1f, RESP_OKAY);
		tick(4);
		pin("irq_down", irq, 1'b0);
		pin("held", ssd, 1'b1);
		rst <= by_rst;
		drv <= by_rst ? 12'h008 : 12'h000;
		tick(6);
		rst <= 1'b0;
		tick(10);
		pin("unlatched", ssd, 1'b0);
		if (by_rst) axi_rd(ADDR_CAUSE, 32'h0, ALL, RESP_OKAY);
	endtask : latch_case
	initial begin
		int cnt;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		// Register map, refusals and random enable patterns
		axi_rd(ADDR_CTRL, 32'h1, ALL, RESP_OKAY);
		axi_rd(ADDR_IRQ_EN, 32'h0, ALL, RESP_OKAY);
		axi_rd(ADDR_IRQ_CLR, 32'h0, ALL, RESP_OKAY);
		axi_wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
		axi_wr(8'h40, 32'h1, RESP_SLVERR);
		axi_rd(8'h40, 32'h0, ALL, RESP_SLVERR);
		repeat (3) begin
			seed = lfsr(seed);
			axi_wr(ADDR_IRQ_EN, {16'h0000, seed}, RESP_OKAY);
			axi_rd(ADDR_IRQ_EN, {27'h0, seed[4:0]}, ALL, RESP_OKAY);
		end
		axi_wr(ADDR_IRQ_EN, 32'h0, RESP_OKAY);
		// Thermal stop with the interrupt masked, then unmasked
		start();
		drv <= 12'h028;
		tick(8);
		pin("hot_gate", gate, 1'b0);
		pin("hot_fault", flt_oe, 1'b0);
		pin("irq_masked", irq, 1'b0);
		axi_rd(ADDR_STATUS, 32'h7, 32'h7, RESP_OKAY);
		drv <= 12'h008;
		tick(8);
		axi_rd(ADDR_STATUS, 32'h3, 32'h7, RESP_OKAY);
		axi_wr(ADDR_IRQ_EN, 32'h1f, RESP_OKAY);
		tick(3);
		pin("irq_sticky", irq, 1'b1);
		// Input lockout retries instead of latching
		drv <= 12'h018;
		tick(8);
		pin("lock_fault", flt_oe, 1'b0);
		pin("lock_gate", gate, 1'b0);
		drv <= 12'h008;
		tick(12);
		pin("lock_back", flt_oe, 1'b1);
		axi_rd(ADDR_STATUS, 32'h3, 32'h7, RESP_OKAY);
		axi_wr(ADDR_IRQ_CLR, 32'h1f, RESP_OKAY);
		// LED sense low alone only raises the output
		drv <= 12'h08a;
		tick(LED_N + 20);
		pin("raise", raise, 1'b1);
		pin("no_latch", ssd, 1'b0);
		// On-time per switching cycle, without and with over-current
		for (int k = 0; k < 2; k++) begin
			drv <= k ? 12'h208 : 12'h008;
			tick(4);
			cnt = 0;
			repeat (64) begin
				@(posedge sys_clk);
				cnt += gate;
			end
			pin("on_time", cnt > 32, k == 0);
		end
		drv <= 12'h000;
		latch_case(12'h800, OPEN_N, CAUSE_OPEN, 1'b0);
		latch_case(12'h400, OVP_N, CAUSE_OVP, 1'b0);
		latch_case(12'h482, LED_N, CAUSE_LED_LOW, 1'b0);
		latch_case(12'h100, 3 * PER, CAUSE_SHORT, 1'b0);
		latch_case(12'h040, 12, CAUSE_LED_OVER, 1'b1);
		report_and_stop();
	end
endmodule : tb_top
